// ===== src/msr_pkg.sv
// Package with register map, field layout and carrier types for the line and modem status block.
//
// Operation
// - Parity-error flag reports the character at the top of the receive queue.
// - Overrun flag sets when a character completes while the receive queue is full.
// - On overrun the new character is dropped; queued data stays intact.
// - Data-ready reads 1 while any received character is held, else 0.
// - Modem status is read-only; writes at its address load extra feature control.
// - Carrier, data-set-ready and clear-to-send change flags set on any change of their status bit (input, or control bit in loopback).
// - Ring change flag sets only when the ring input goes from 0 to 1, or in loopback when modem control bit 2 goes from 1 to 0.
// - Reading modem status clears the change flags that the read returned.
// - Modem interrupt is raised while any change flag is 1.
// - Bit 7 is inverted carrier input, or modem control bit 3 in loopback.
// - Bit 6 is inverted ring input, or modem control bit 2 in loopback.
// - Bit 5 is inverted data-set-ready input, or modem control bit 0 in loopback.
// - Bit 4 is inverted clear-to-send input, or modem control bit 1 in loopback.
package msr_pkg;

    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int RX_DEPTH  = 128;
    localparam int PTR_W     = 7;
    localparam int CNT_W     = 8;

    localparam logic [ADDR_W-1:0] REG_LINE_STATUS   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MODEM_STATUS  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_MODEM_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RX_CONTROL    = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_RX_DATA       = 8'h10;
    localparam logic [ADDR_W-1:0] REG_RX_LEVEL      = 8'h14;

    // Line status fields.
    localparam int LS_DATA_READY = 0;
    localparam int LS_OVERRUN    = 1;
    localparam int LS_PARITY     = 2;

    // Modem status fields: change flags in the low nibble, levels in the high one.
    localparam int MS_DELTA_LO = 0;
    localparam int MS_LEVEL_LO = 4;
    localparam int MS_NIBBLE   = 4;
    localparam int RI_IDX      = 2;

    // Modem control fields.
    localparam int MC_DTR      = 0;
    localparam int MC_RTS      = 1;
    localparam int MC_OUT1     = 2;
    localparam int MC_OUT2     = 3;
    localparam int MC_LOOPBACK = 4;
    localparam int MC_W        = 5;

    // Receive control fields; flush is self-clearing.
    localparam int RC_FIFO_EN = 0;
    localparam int RC_FLUSH   = 1;

    localparam int EFC_W = 3;

    localparam logic [MC_W-1:0]   MODEM_CONTROL_RST = 5'h00;
    localparam logic [EFC_W-1:0]  EFC_RST           = 3'h0;
    localparam logic [DATA_W-1:0] READ_ZERO         = 32'h0000_0000;

    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } modem_in_s;

    typedef struct packed {
        logic out2_n;
        logic out1_n;
        logic rts_n;
        logic dtr_n;
    } modem_out_s;

    typedef struct packed {
        logic       parity_err;
        logic [7:0] data;
    } rx_char_s;

    localparam modem_out_s MODEM_OUT_IDLE = 4'hf;

    typedef enum logic {
        APB_IDLE,
        APB_ACK
    } apb_state_e;

endpackage

// ===== src/modem_change_detect.sv
// Change detector for the four modem status levels with read-clear flags.
module modem_change_detect
    import msr_pkg::*;
(
    input  wire logic                 pclk,       // system clock
    input  wire logic                 presetn,    // async reset, active low
    input  wire logic [MS_NIBBLE-1:0] level,      // active-high status levels
    input  wire logic [MS_NIBBLE-1:0] clear_mask, // change flags to clear this cycle
    output logic      [MS_NIBBLE-1:0] delta_d,    // next value of change flags
    output logic      [MS_NIBBLE-1:0] delta_q     // change flags
);

    logic [MS_NIBBLE-1:0] level_q;
    logic                 primed_q;

    ////////////////////////////////////////////////////////////////////////////
    // The first cycle after reset only records levels, so that inputs which
    // already sit active at reset release do not show up as changes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_q  <= 4'h0;
            primed_q <= 1'b0;
        end
        else
        begin
            level_q  <= level;
            primed_q <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < MS_NIBBLE; i++)
        begin : g_bit
            logic change;
            if (i == RI_IDX)
            begin : g_ring
                // Status level is the inverted pin, so a pin rise is a level fall.
                assign change = primed_q & level_q[i] & ~level[i];
            end
            else
            begin : g_any
                assign change = primed_q & (level_q[i] ^ level[i]);
            end
            // A change landing in the clearing cycle survives.
            assign delta_d[i] = (delta_q[i] & ~clear_mask[i]) | change;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            delta_q <= 4'h0;
        end
        else
        begin
            delta_q <= delta_d;
        end
    end

endmodule

// ===== src/uart_line_and_modem_status.sv
// Line and modem status logic of one UART channel with its APB register port.
module uart_line_and_modem_status
    import msr_pkg::*;
(
    input  wire logic                      pclk,                  // system clock
    input  wire logic                      presetn,               // async reset, active low
    input  wire logic [msr_pkg::ADDR_W-1:0] paddr,                // APB byte address
    input  wire logic                      psel,                  // APB select
    input  wire logic                      penable,               // APB access phase
    input  wire logic                      pwrite,                // APB write
    input  wire logic [msr_pkg::DATA_W-1:0] pwdata,               // APB write data
    output logic      [msr_pkg::DATA_W-1:0] prdata,               // APB read data
    output logic                           pready,                // APB ready
    output logic                           pslverr,               // APB error
    input  wire msr_pkg::modem_in_s        modem_in,              // modem pins, active low
    input  wire logic                      rx_valid,              // character complete pulse
    input  wire msr_pkg::rx_char_s         rx_char,               // completed character
    output msr_pkg::modem_out_s            modem_out,             // modem pins, active low
    output logic      [msr_pkg::EFC_W-1:0] extra_feature_control, // register set select
    output logic                           modem_irq              // modem status interrupt
);

    import msr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state.

    apb_state_e           state_q;
    logic [DATA_W-1:0]    prdata_q;
    logic [DATA_W-1:0]    rdata_d;
    logic                 pready_q;
    logic                 pslverr_q;
    logic                 err_d;
    logic                 setup_acc;
    logic                 commit;
    logic                 rd_commit;
    logic                 wr_commit;

    ////////////////////////////////////////////////////////////////////////////
    // Control and status state.

    logic [MC_W-1:0]      modem_control_q;
    logic [EFC_W-1:0]     efc_q;
    logic                 fifo_en_q;
    logic                 overrun_q;
    logic                 overrun_d;
    logic                 overrun_seen_q;
    logic [MS_NIBBLE-1:0] delta_seen_q;
    logic [MS_NIBBLE-1:0] delta_clear;
    logic [MS_NIBBLE-1:0] delta_d;
    logic [MS_NIBBLE-1:0] delta_q;
    logic [MS_NIBBLE-1:0] level;
    logic                 loopback;
    logic                 modem_irq_q;
    modem_out_s           modem_out_q;

    ////////////////////////////////////////////////////////////////////////////
    // Receive queue state.

    rx_char_s             rx_mem_q [RX_DEPTH];
    logic [PTR_W-1:0]     wr_ptr_q;
    logic [PTR_W-1:0]     rd_ptr_q;
    logic [CNT_W-1:0]     count_q;
    logic [CNT_W-1:0]     capacity;
    logic                 full;
    logic                 push;
    logic                 pop;
    logic                 flush;
    logic                 top_parity;
    logic                 data_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: setup, one access cycle with pready low, then pready high.
    // Read data is captured when pready rises; side effects happen at the
    // completing edge only, so a held request never acts twice.

    assign setup_acc = psel & penable & (state_q == APB_IDLE);
    assign commit    = psel & penable & (state_q == APB_ACK);
    assign rd_commit = commit & ~pwrite;
    assign wr_commit = commit & pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= APB_IDLE;
        end
        else
        begin
            unique case (state_q)
                APB_IDLE:
                begin
                    if (setup_acc)
                    begin
                        state_q <= APB_ACK;
                    end
                end
                APB_ACK:
                begin
                    state_q <= APB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= READ_ZERO;
        end
        else
        begin
            pready_q  <= setup_acc;
            pslverr_q <= setup_acc & err_d;
            if (setup_acc)
            begin
                prdata_q <= pwrite ? READ_ZERO : rdata_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and address decode. Unmapped addresses answer with an error and
    // zero data; line status and receive level writes are silently ignored, modem status writes set the register-set select.

    always_comb
    begin
        rdata_d = READ_ZERO;
        err_d   = 1'b0;
        unique case (paddr)
            REG_LINE_STATUS:
            begin
                rdata_d[LS_DATA_READY] = data_ready;
                rdata_d[LS_OVERRUN]    = overrun_q;
                rdata_d[LS_PARITY]     = top_parity;
            end
            REG_MODEM_STATUS:
            begin
                rdata_d[MS_DELTA_LO +: MS_NIBBLE] = delta_q;
                rdata_d[MS_LEVEL_LO +: MS_NIBBLE] = level;
            end
            REG_MODEM_CONTROL:
            begin
                rdata_d[MC_W-1:0] = modem_control_q;
            end
            REG_RX_CONTROL:
            begin
                rdata_d[RC_FIFO_EN] = fifo_en_q;
            end
            REG_RX_DATA:
            begin
                rdata_d[7:0] = data_ready ? rx_mem_q[rd_ptr_q].data : 8'h00;
            end
            REG_RX_LEVEL:
            begin
                rdata_d[CNT_W-1:0] = count_q;
            end
            default:
            begin
                err_d = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written control.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            modem_control_q <= MODEM_CONTROL_RST;
        end
        else if (wr_commit && paddr == REG_MODEM_CONTROL)
        begin
            modem_control_q <= pwdata[MC_W-1:0];
        end
    end

    // The status address takes writes into the register-set select instead.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            efc_q <= EFC_RST;
        end
        else if (wr_commit && paddr == REG_MODEM_STATUS)
        begin
            efc_q <= pwdata[EFC_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fifo_en_q <= 1'b0;
        end
        else if (wr_commit && paddr == REG_RX_CONTROL)
        begin
            fifo_en_q <= pwdata[RC_FIFO_EN];
        end
    end

    // Switching the queue mode or asking for a flush empties the queue.
    assign flush = wr_commit && paddr == REG_RX_CONTROL
                   && (pwdata[RC_FLUSH] || pwdata[RC_FIFO_EN] != fifo_en_q);

    ////////////////////////////////////////////////////////////////////////////
    // Receive queue. Without queue mode it holds a single character, which then
    // acts as the holding register.

    assign capacity   = fifo_en_q ? CNT_W'(RX_DEPTH) : CNT_W'(1);
    assign full       = count_q >= capacity;
    assign push       = rx_valid & ~full & ~flush;
    assign pop        = rd_commit && paddr == REG_RX_DATA && data_ready && !flush;
    assign data_ready = count_q != '0;
    assign top_parity = data_ready & rx_mem_q[rd_ptr_q].parity_err;

    always_ff @(posedge pclk)
    begin
        if (push)
        begin
            rx_mem_q[wr_ptr_q] <= rx_char;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= fifo_en_q ? wr_ptr_q + PTR_W'(1) : '0;
            end
            if (pop)
            begin
                rd_ptr_q <= fifo_en_q ? rd_ptr_q + PTR_W'(1) : '0;
            end
            count_q <= count_q + CNT_W'(push) - CNT_W'(pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overrun flag. Only a flag value that software actually saw is cleared by
    // the status read, so an overrun landing during the read is kept.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overrun_seen_q <= 1'b0;
        end
        else if (setup_acc)
        begin
            overrun_seen_q <= !pwrite && paddr == REG_LINE_STATUS && overrun_q;
        end
    end

    always_comb
    begin
        overrun_d = overrun_q;
        if (rd_commit && paddr == REG_LINE_STATUS && overrun_seen_q)
        begin
            overrun_d = 1'b0;
        end
        if (rx_valid && full)
        begin
            overrun_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overrun_q <= 1'b0;
        end
        else
        begin
            overrun_q <= overrun_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modem status levels, with loopback substitution from modem control.

    assign loopback = modem_control_q[MC_LOOPBACK];

    always_comb
    begin
        if (loopback)
        begin
            level[3] = modem_control_q[MC_OUT2];
            level[2] = modem_control_q[MC_OUT1];
            level[1] = modem_control_q[MC_DTR];
            level[0] = modem_control_q[MC_RTS];
        end
        else
        begin
            level[3] = ~modem_in.cd_n;
            level[2] = ~modem_in.ri_n;
            level[1] = ~modem_in.dsr_n;
            level[0] = ~modem_in.cts_n;
        end
    end

    // Flags seen by a modem status read are the ones its completion clears.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            delta_seen_q <= '0;
        end
        else if (setup_acc)
        begin
            delta_seen_q <= (!pwrite && paddr == REG_MODEM_STATUS) ? delta_q : '0;
        end
    end

    assign delta_clear = (rd_commit && paddr == REG_MODEM_STATUS) ? delta_seen_q : '0;

    modem_change_detect u_change
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .level      (level),
        .clear_mask (delta_clear),
        .delta_d    (delta_d),
        .delta_q    (delta_q)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            modem_irq_q <= 1'b0;
        end
        else
        begin
            modem_irq_q <= |delta_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modem output pins. In loopback they are parked inactive so the far end
    // sees no traffic while the outputs are folded back into the status.

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            modem_out_q <= MODEM_OUT_IDLE;
        end
        else if (loopback)
        begin
            modem_out_q <= MODEM_OUT_IDLE;
        end
        else
        begin
            modem_out_q.out2_n <= ~modem_control_q[MC_OUT2];
            modem_out_q.out1_n <= ~modem_control_q[MC_OUT1];
            modem_out_q.rts_n  <= ~modem_control_q[MC_RTS];
            modem_out_q.dtr_n  <= ~modem_control_q[MC_DTR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign modem_out             = modem_out_q;
    assign extra_feature_control = efc_q;
    assign modem_irq             = modem_irq_q;

endmodule

// ===== test/modem_peer.sv
// Behavioural modem peer that drives the active-low modem pins of the block.
module modem_peer
(
    input  wire logic       pclk,     // system clock
    input  wire logic [3:0] level,    // wanted levels, active high: cd ri dsr cts
    input  wire logic       slow,     // answer two cycles late
    output msr_pkg::modem_in_s modem_in  // modem pins, active low
);
    timeunit 1ns;
    timeprecision 100ps;
    import msr_pkg::*;

    logic [3:0] late_q;

    always @(posedge pclk)
    begin
        late_q   <= ~level;
        modem_in <= slow ? late_q : ~level;
    end
endmodule

// ===== test/line_status_checker_properties.sv
// Concurrent checks on the ports of the line and modem status block.
module line_status_checker
(
    input wire logic                       pclk,                  // system clock
    input wire logic                       presetn,               // async reset, active low
    input wire logic [msr_pkg::ADDR_W-1:0] paddr,                 // APB address
    input wire logic                       psel,                  // APB select
    input wire logic                       penable,               // APB access phase
    input wire logic                       pwrite,                // APB write
    input wire logic [msr_pkg::DATA_W-1:0] prdata,                // APB read data
    input wire logic                       pready,                // APB ready
    input wire logic                       pslverr,               // APB error
    input wire msr_pkg::modem_in_s         modem_in,              // modem pins
    input wire msr_pkg::modem_out_s        modem_out,             // modem outputs
    input wire logic                       modem_irq              // modem interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    import msr_pkg::*;

    logic [2:0] age_q;
    logic [2:0] quiet_q;
    logic       rd_ms;
    logic       no_loop;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The block only records levels in its first cycle, so checks wait a while.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            age_q <= 3'h0;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            quiet_q <= 3'h0;
        else if ($changed(modem_in))
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end

    assign rd_ms   = psel && penable && pready && !pwrite && paddr == REG_MODEM_STATUS;
    // All-ones outputs may also mean plain zero control bits; such cycles are skipped.
    assign no_loop = modem_out != MODEM_OUT_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_one_wait;
        !pready ##1 pready;
    endsequence

    a_one_wait: assert property (s_setup ##1 (psel && penable) |-> s_one_wait)
        else $error("access phase did not take exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_error_zero: assert property (pslverr |-> pready && prdata == READ_ZERO)
        else $error("error response without ready or with data");
    a_write_zero: assert property (pready && pwrite |-> prdata == READ_ZERO)
        else $error("write returned read data");
    a_change_irq: assert property (age_q == 3'h7 && no_loop && ($changed({modem_in.cd_n,
        modem_in.dsr_n, modem_in.cts_n}) || $rose(modem_in.ri_n)) |-> ##[1:2] modem_irq)
        else $error("modem input change raised no interrupt");
    a_ring_fall: assert property (age_q == 3'h7 && no_loop && !psel && !modem_irq
        && quiet_q >= 3'h2 && $fell(modem_in.ri_n) && $stable({modem_in.cd_n,
        modem_in.dsr_n, modem_in.cts_n}) |=> !modem_irq [*2])
        else $error("ring input leaving rest set a change flag");
    a_read_clears: assert property (age_q == 3'h7 && rd_ms && quiet_q >= 3'h4 |=> !modem_irq)
        else $error("interrupt stayed after modem status read");
    a_level_bits: assert property (rd_ms && no_loop && quiet_q >= 3'h3
        |-> prdata[7:4] == ~modem_in)
        else $error("modem status levels differ from the pins");
endmodule

bind uart_line_and_modem_status line_status_checker line_status_checker_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_in(modem_in), .modem_out(modem_out), .modem_irq(modem_irq));

// ===== test/uart_line_and_modem_status_tb_top.sv
// Self-checking testbench for the line and modem status block.
module uart_line_and_modem_status_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import msr_pkg::*;

    logic              pclk;
    logic              presetn  = 1'b0;
    logic              psel     = 1'b0;
    logic              penable  = 1'b0;
    logic              pwrite   = 1'b0;
    logic [ADDR_W-1:0] paddr    = 8'h00;
    logic [DATA_W-1:0] pwdata   = 32'h0;
    logic              rx_valid = 1'b0;
    rx_char_s          rx_char  = 9'h000;
    logic [3:0]        level    = 4'h0;
    logic              slow     = 1'b0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd_q;
    logic [DATA_W-1:0] exp;
    logic              pready;
    logic              pslverr;
    logic              err_q;
    logic              modem_irq;
    logic [EFC_W-1:0]  efc;
    modem_in_s         modem_in;
    modem_out_s        modem_out;
    int                i;
    int                miscompares = 0;
    int                compares = 0;

    uart_line_and_modem_status uart_line_and_modem_status_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .modem_in(modem_in), .rx_valid(rx_valid), .rx_char(rx_char),
        .modem_out(modem_out), .extra_feature_control(efc), .modem_irq(modem_irq));

    modem_peer modem_peer_inst (.pclk(pclk), .level(level), .slow(slow), .modem_in(modem_in));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] want, input logic [31:0] got);
        compares++;
        if (got !== want)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, got);
        end
    endtask

    // The request is held until ready is seen; only the watchdog ends a wait.
    // Registered side effects settle one edge after completion, so it returns late.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(negedge pclk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] want, input logic [31:0] mask,
                       input string name);
        xfer(a, 1'b0, 32'h0);
        chk(name, want, rd_q & mask);
    endtask

    task automatic send(input logic p, input logic [7:0] d);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_char  <= {p, d};
        @(posedge pclk);
        rx_valid <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("modem_out reset", 32'hf, modem_out);
        rdc(REG_LINE_STATUS, 32'h0, '1, "line_status reset");
        rdc(REG_MODEM_STATUS, 32'h0, '1, "modem_status reset");
        xfer(8'h18, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, err_q);
        xfer(REG_MODEM_STATUS, 1'b1, 32'h5);
        chk("extra_feature_control", 32'h5, efc);
        rdc(REG_MODEM_STATUS, 32'h0, '1, "modem_status after write");
        $display("test registers done");
        xfer(REG_MODEM_CONTROL, 1'b1, 32'h1);
        chk("modem_out dtr", 32'he, modem_out);
        for (i = 0; i < 4; i++)
        begin
            slow <= i[0];
            level <= 4'h1 << i;
            repeat (6) @(posedge pclk);
            exp = (32'h10 << i) | (i == 2 ? 32'h0 : 32'h1 << i);
            chk("irq on", 32'(i != 2), modem_irq);
            rdc(REG_MODEM_STATUS, exp, '1, "change on");
            rdc(REG_MODEM_STATUS, 32'h10 << i, '1, "flags cleared");
            repeat (2) @(posedge pclk);
            chk("irq cleared", 32'h0, modem_irq);
            level <= 4'h0;
            repeat (6) @(posedge pclk);
            rdc(REG_MODEM_STATUS, 32'h1 << i, '1, "change off");
        end
        $display("test modem pins done");
        level <= 4'hf;
        for (i = 0; i < 4; i++)
        begin
            exp = 32'h1 << i;
            xfer(REG_MODEM_CONTROL, 1'b1, 32'h10 | exp);
            chk("modem_out loopback", 32'hf, modem_out);
            exp = {24'h0, exp[3], exp[2], exp[0], exp[1], 4'h0};
            rdc(REG_MODEM_STATUS, exp, 32'hf0, "loopback levels");
        end
        level <= 4'h0;
        xfer(REG_MODEM_CONTROL, 1'b1, 32'h1);
        repeat (6) @(posedge pclk);
        xfer(REG_MODEM_STATUS, 1'b0, 32'h0);
        rdc(REG_MODEM_STATUS, 32'h0, '1, "loopback left");
        $display("test loopback done");
        send(1'b1, 8'h5a);
        rdc(REG_LINE_STATUS, 32'h5, '1, "parity and ready");
        send(1'b0, 8'h33);
        rdc(REG_LINE_STATUS, 32'h7, '1, "holding overrun");
        rdc(REG_RX_DATA, 32'h5a, '1, "first char kept");
        rdc(REG_LINE_STATUS, 32'h0, '1, "nothing held");
        xfer(REG_RX_CONTROL, 1'b1, 32'h1);
        for (i = 0; i < RX_DEPTH; i++)
            send(i == 0, i[7:0]);
        rdc(REG_LINE_STATUS, 32'h5, '1, "queue full");
        send(1'b0, 8'hff);
        rdc(REG_LINE_STATUS, 32'h7, '1, "queue overrun");
        rdc(REG_RX_LEVEL, 32'h80, '1, "queue level");
        rdc(REG_RX_DATA, 32'h0, '1, "queue head");
        rdc(REG_LINE_STATUS, 32'h1, '1, "next head clean");
        $display("test receive done");
        tally_and_finish;
    end

    // The tests take about 530 cycles; over thirty-five times that means a hang.
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        tally_and_finish;
    end
endmodule
